// *** src/bsil_chain.sv ***
/*
  Boundary scan chain: shift stages plus falling-edge update latches.
  Assumes capture and shift strobes arrive on test clock rising edges
  and update strobes on falling edges, one system cycle each.
*/
`timescale 1ns/1ps
`default_nettype none

module bsil_chain #(
  parameter int LEN = 8
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Chain bundle
  bsil_chain_if.chain ch
);
  logic [LEN-1:0] sr_q;
  logic [LEN-1:0] sr_d;
  logic [LEN-1:0] upd_q;
  logic [LEN-1:0] upd_d;

  // ----------------------------------------------------------------
  // Capture, shift and update
  // ----------------------------------------------------------------
  always_comb
  begin
    sr_d = sr_q;
    upd_d = upd_q;
    if (ch.capture)
      sr_d = ch.cap;
    else if (ch.shift)
      sr_d = {ch.tdi, sr_q[LEN-1:1]};
    if (ch.update)
      upd_d = sr_q;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      sr_q <= '0;
      upd_q <= '0;
    end
    else
    begin
      sr_q <= sr_d;
      upd_q <= upd_d;
    end
  end

  assign ch.so = sr_q[0];
  assign ch.upd = upd_q;
endmodule

`default_nettype wire

// *** src/bsil_chain_if.sv ***
/*
  Control and data bundle between the test port and the boundary chain.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface bsil_chain_if #(
  parameter int LEN = 8
);
  logic capture;
  logic shift;
  logic update;
  logic tdi;
  logic [LEN-1:0] cap;
  logic [LEN-1:0] upd;
  logic so;

  modport ctrl (
    output capture,
    output shift,
    output update,
    output tdi,
    output cap,
    input upd,
    input so
  );

  modport chain (
    input capture,
    input shift,
    input update,
    input tdi,
    input cap,
    output upd,
    output so
  );
endinterface

`default_nettype wire

// *** src/bsil_pkg.sv ***
/*
  Constants and types shared by the boundary-scan instruction logic.
  Assumes nothing of its surroundings; imported by scope only.
*/
package bsil_pkg;

  // ----------------------------------------------------------------
  // Instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 6;
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_IDCODE = 6'h02;
  localparam logic [5:0] OP_HIGHZ = 6'h03;
  localparam logic [5:0] OP_CLAMP = 6'h3E;
  localparam logic [5:0] OP_BYPASS = 6'h3F;
  localparam logic [5:0] CAPTURE_IR_PATTERN_INSTR = 6'h2D;
  localparam logic [5:0] IR_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Data registers
  // ----------------------------------------------------------------
  localparam int ID_W = 32;
  localparam logic ID_LSB = 1'h1;
  localparam logic BYPASS_CAPTURE = 1'h0;

  // ----------------------------------------------------------------
  // Synchroniser depth and test port states
  // ----------------------------------------------------------------
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    TAP_RESET = 4'h0,
    TAP_IDLE = 4'h1,
    TAP_SEL_DR = 4'h2,
    TAP_CAP_DR = 4'h3,
    TAP_SHIFT_DR = 4'h4,
    TAP_EXIT1_DR = 4'h5,
    TAP_PAUSE_DR = 4'h6,
    TAP_EXIT2_DR = 4'h7,
    TAP_UPD_DR = 4'h8,
    TAP_SEL_IR = 4'h9,
    TAP_CAP_IR = 4'hA,
    TAP_SHIFT_IR = 4'hB,
    TAP_EXIT1_IR = 4'hC,
    TAP_PAUSE_IR = 4'hD,
    TAP_EXIT2_IR = 4'hE,
    TAP_UPD_IR = 4'hF
  } bsil_tap_e;

endpackage

// *** src/bsil_sync.sv ***
/*
  Two-stage synchroniser for a vector of asynchronous levels.
  Assumes each bit is an independent level from another clock domain.
*/
`timescale 1ns/1ps
`default_nettype none

module bsil_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= async_i;
      sync_q <= meta_q;
    end
  end

  assign sync_o = sync_q;
endmodule

`default_nettype wire

// *** src/bsil_top.sv ***
/*
  Boundary-scan instruction logic: test port state tracking, six-bit
  instruction register and decode, bypass, identification and boundary
  chain selection, and pin control for output and two-way pins.
  Assumes the test clock is at most a quarter of clock_i, and that
  tck, tms, tdi, trst_n and pad inputs are asynchronous to clock_i while
  core signals share clock_i.
*/
`timescale 1ns/1ps
`default_nettype none

module bsil_top #(
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_BIDIR = 4,
  // Identification fields; values are arbitrary
  parameter logic [3:0] ID_VERSION = 4'h1,
  parameter logic [15:0] ID_PART = 16'h0A5C,
  parameter logic [10:0] ID_MANUF = 11'h2B4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Test port
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  // Input-only pads
  input wire logic [N_IN-1:0] in_pad_i,
  // Output pads and core data
  input wire logic [N_OUT-1:0] core_out_i,
  output logic [N_OUT-1:0] out_pad_o,
  output logic [N_OUT-1:0] out_pad_oe_o,
  // Two-way pads and core data
  input wire logic [N_BIDIR-1:0] bd_core_out_i,
  input wire logic [N_BIDIR-1:0] bd_core_oe_i,
  input wire logic [N_BIDIR-1:0] bd_pad_i,
  output logic [N_BIDIR-1:0] bd_pad_o,
  output logic [N_BIDIR-1:0] bd_pad_oe_o
);
  localparam int LEN = N_IN + N_OUT + 2 * N_BIDIR;
  localparam int PADS = N_IN + N_BIDIR;
  localparam int OUT_LO = N_IN;
  localparam int OE_LO = N_IN + N_OUT;
  localparam int BD_LO = N_IN + N_OUT + N_BIDIR;
  localparam logic [bsil_pkg::ID_W-1:0] ID_VALUE =
    {ID_VERSION, ID_PART, ID_MANUF, bsil_pkg::ID_LSB};

  // ----------------------------------------------------------------
  // Input synchronisation and test clock edges
  // ----------------------------------------------------------------
  logic [3:0] port_s;
  logic [PADS-1:0] pad_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic tck_prev_q;
  logic tck_rise;
  logic tck_fall;
  logic [N_IN-1:0] in_pad_s;
  logic [N_BIDIR-1:0] bd_pad_s;

  bsil_sync #(
    .WIDTH(4),
    .RST_VAL(4'h0)
  ) u_port_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({trst_n_i, tdi_i, tms_i, tck_i}),
    .sync_o(port_s)
  );

  bsil_sync #(
    .WIDTH(PADS),
    .RST_VAL('0)
  ) u_pad_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .async_i({bd_pad_i, in_pad_i}),
    .sync_o(pad_s)
  );

  assign tck_s = port_s[0];
  assign tms_s = port_s[1];
  assign tdi_s = port_s[2];
  assign trst_n_s = port_s[3];
  assign in_pad_s = pad_s[N_IN-1:0];
  assign bd_pad_s = pad_s[PADS-1:N_IN];
  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      tck_prev_q <= 1'h0;
    else
      tck_prev_q <= tck_s;
  end

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  bsil_pkg::bsil_tap_e tap_q;
  bsil_pkg::bsil_tap_e tap_d;
  logic [bsil_pkg::IR_W-1:0] ir_sr_q;
  logic [bsil_pkg::IR_W-1:0] ir_sr_d;
  logic [bsil_pkg::IR_W-1:0] instr_q;
  logic [bsil_pkg::IR_W-1:0] instr_d;
  logic byp_q;
  logic byp_d;
  logic [bsil_pkg::ID_W-1:0] id_sr_q;
  logic [bsil_pkg::ID_W-1:0] id_sr_d;
  logic tdo_q;
  logic tdo_d;
  logic tdo_oe_q;
  logic tdo_oe_d;
  logic is_extest;
  logic is_sample;
  logic is_idcode;
  logic is_highz;
  logic is_clamp;
  logic sel_bsr;
  logic dr_so;

  bsil_chain_if #(.LEN(LEN)) ch_if ();

  assign is_extest = (instr_q == bsil_pkg::OP_EXTEST);
  assign is_sample = (instr_q == bsil_pkg::OP_SAMPLE);
  assign is_idcode = (instr_q == bsil_pkg::OP_IDCODE);
  assign is_highz = (instr_q == bsil_pkg::OP_HIGHZ);
  assign is_clamp = (instr_q == bsil_pkg::OP_CLAMP);
  assign sel_bsr = is_extest | is_sample;

  // Bypass is the path for highz, clamp, bypass and all other codes
  assign dr_so = sel_bsr ? ch_if.so :
                 (is_idcode ? id_sr_q[0] : byp_q);

  // ----------------------------------------------------------------
  // Boundary chain
  // ----------------------------------------------------------------
  logic [N_BIDIR-1:0] bd_sel_core;
  logic [N_BIDIR-1:0] bd_cap;

  // Two-way capture mux follows the enable unless extest is active
  assign bd_sel_core = bd_core_oe_i & {N_BIDIR{~is_extest}};

  assign ch_if.capture = tck_rise & (tap_q == bsil_pkg::TAP_CAP_DR) &
                         sel_bsr;
  assign ch_if.shift = tck_rise & (tap_q == bsil_pkg::TAP_SHIFT_DR) &
                       sel_bsr;
  assign ch_if.update = tck_fall & (tap_q == bsil_pkg::TAP_UPD_DR) &
                        sel_bsr;
  assign ch_if.tdi = tdi_s;
  assign bd_cap = (bd_core_out_i & bd_sel_core) |
                  (bd_pad_s & ~bd_sel_core);
  // Input cells only observe the pad
  assign ch_if.cap = {bd_cap, bd_core_oe_i, core_out_i,
                      in_pad_s};

  bsil_chain #(
    .LEN(LEN)
  ) u_chain (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .ch(ch_if.chain)
  );

  // ----------------------------------------------------------------
  // Test port state, instruction and data registers
  // ----------------------------------------------------------------
  always_comb
  begin
    tap_d = tap_q;
    ir_sr_d = ir_sr_q;
    instr_d = instr_q;
    byp_d = byp_q;
    id_sr_d = id_sr_q;
    tdo_d = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_rise)
    begin
      case (tap_q)
        bsil_pkg::TAP_RESET:
          tap_d = tms_s ? bsil_pkg::TAP_RESET : bsil_pkg::TAP_IDLE;
        bsil_pkg::TAP_IDLE:
          tap_d = tms_s ? bsil_pkg::TAP_SEL_DR : bsil_pkg::TAP_IDLE;
        bsil_pkg::TAP_SEL_DR:
          tap_d = tms_s ? bsil_pkg::TAP_SEL_IR : bsil_pkg::TAP_CAP_DR;
        bsil_pkg::TAP_CAP_DR:
        begin
          byp_d = bsil_pkg::BYPASS_CAPTURE;
          if (is_idcode)
            id_sr_d = ID_VALUE;
          tap_d = tms_s ? bsil_pkg::TAP_EXIT1_DR : bsil_pkg::TAP_SHIFT_DR;
        end
        bsil_pkg::TAP_SHIFT_DR:
        begin
          byp_d = tdi_s;
          if (is_idcode)
            id_sr_d = {tdi_s, id_sr_q[bsil_pkg::ID_W-1:1]};
          tap_d = tms_s ? bsil_pkg::TAP_EXIT1_DR : bsil_pkg::TAP_SHIFT_DR;
        end
        bsil_pkg::TAP_EXIT1_DR:
          tap_d = tms_s ? bsil_pkg::TAP_UPD_DR : bsil_pkg::TAP_PAUSE_DR;
        bsil_pkg::TAP_PAUSE_DR:
          tap_d = tms_s ? bsil_pkg::TAP_EXIT2_DR : bsil_pkg::TAP_PAUSE_DR;
        bsil_pkg::TAP_EXIT2_DR:
          tap_d = tms_s ? bsil_pkg::TAP_UPD_DR : bsil_pkg::TAP_SHIFT_DR;
        bsil_pkg::TAP_UPD_DR:
          tap_d = tms_s ? bsil_pkg::TAP_SEL_DR : bsil_pkg::TAP_IDLE;
        bsil_pkg::TAP_SEL_IR:
          tap_d = tms_s ? bsil_pkg::TAP_RESET : bsil_pkg::TAP_CAP_IR;
        bsil_pkg::TAP_CAP_IR:
        begin
          ir_sr_d = bsil_pkg::CAPTURE_IR_PATTERN_INSTR;
          tap_d = tms_s ? bsil_pkg::TAP_EXIT1_IR : bsil_pkg::TAP_SHIFT_IR;
        end
        bsil_pkg::TAP_SHIFT_IR:
        begin
          ir_sr_d = {tdi_s, ir_sr_q[bsil_pkg::IR_W-1:1]};
          tap_d = tms_s ? bsil_pkg::TAP_EXIT1_IR : bsil_pkg::TAP_SHIFT_IR;
        end
        bsil_pkg::TAP_EXIT1_IR:
          tap_d = tms_s ? bsil_pkg::TAP_UPD_IR : bsil_pkg::TAP_PAUSE_IR;
        bsil_pkg::TAP_PAUSE_IR:
          tap_d = tms_s ? bsil_pkg::TAP_EXIT2_IR : bsil_pkg::TAP_PAUSE_IR;
        bsil_pkg::TAP_EXIT2_IR:
          tap_d = tms_s ? bsil_pkg::TAP_UPD_IR : bsil_pkg::TAP_SHIFT_IR;
        bsil_pkg::TAP_UPD_IR:
          tap_d = tms_s ? bsil_pkg::TAP_SEL_DR : bsil_pkg::TAP_IDLE;
        default:
          tap_d = bsil_pkg::TAP_RESET;
      endcase
    end
    if (tck_fall)
    begin
      if (tap_q == bsil_pkg::TAP_UPD_IR)
        instr_d = ir_sr_q;
      tdo_oe_d = (tap_q == bsil_pkg::TAP_SHIFT_DR) ||
                 (tap_q == bsil_pkg::TAP_SHIFT_IR);
      tdo_d = (tap_q == bsil_pkg::TAP_SHIFT_IR) ? ir_sr_q[0] : dr_so;
    end
    if (!trst_n_s)
      tap_d = bsil_pkg::TAP_RESET;
    if ((tap_q == bsil_pkg::TAP_RESET) || !trst_n_s)
      instr_d = bsil_pkg::OP_IDCODE;
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      tap_q <= bsil_pkg::TAP_RESET;
      ir_sr_q <= bsil_pkg::IR_RESET;
      instr_q <= bsil_pkg::OP_IDCODE;
      byp_q <= 1'h0;
      id_sr_q <= '0;
      tdo_q <= 1'h0;
      tdo_oe_q <= 1'h0;
    end
    else
    begin
      tap_q <= tap_d;
      ir_sr_q <= ir_sr_d;
      instr_q <= instr_d;
      byp_q <= byp_d;
      id_sr_q <= id_sr_d;
      tdo_q <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin control
  // ----------------------------------------------------------------
  logic drive_bsr;
  logic [N_OUT-1:0] out_q;
  logic [N_OUT-1:0] out_d;
  logic [N_OUT-1:0] out_oe_q;
  logic [N_OUT-1:0] out_oe_d;
  logic [N_BIDIR-1:0] bd_q;
  logic [N_BIDIR-1:0] bd_d;
  logic [N_BIDIR-1:0] bd_oe_q;
  logic [N_BIDIR-1:0] bd_oe_d;

  assign drive_bsr = is_extest | is_clamp;

  always_comb
  begin
    out_d = core_out_i;
    out_oe_d = {N_OUT{1'h1}};
    bd_d = bd_core_out_i;
    bd_oe_d = bd_core_oe_i;
    if (drive_bsr)
    begin
      out_d = ch_if.upd[OE_LO-1:OUT_LO];
      bd_d = ch_if.upd[LEN-1:BD_LO];
      bd_oe_d = ch_if.upd[BD_LO-1:OE_LO];
    end
    if (is_highz)
    begin
      out_oe_d = '0;
      bd_oe_d = '0;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      out_q <= '0;
      out_oe_q <= '0;
      bd_q <= '0;
      bd_oe_q <= '0;
    end
    else
    begin
      out_q <= out_d;
      out_oe_q <= out_oe_d;
      bd_q <= bd_d;
      bd_oe_q <= bd_oe_d;
    end
  end

  assign tdo_o = tdo_q;
  assign tdo_oe_o = tdo_oe_q;
  assign out_pad_o = out_q;
  assign out_pad_oe_o = out_oe_q;
  assign bd_pad_o = bd_q;
  assign bd_pad_oe_o = bd_oe_q;
endmodule

`default_nettype wire

// *** verification/bsil_checker.sv ***
/*
  Port checker for bsil_top, bound into every instance.
  Assumes a test clock low phase of at least four system cycles.
*/
`timescale 1ns/1ps
`default_nettype none

module bsil_checker #(
  parameter int N_OUT = 4,
  parameter int N_BIDIR = 4
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Test port
  input wire logic tck_i,
  input wire logic trst_n_i,
  input wire logic tdo_o,
  input wire logic tdo_oe_o,
  // Pads
  input wire logic [N_OUT-1:0] out_pad_oe_o,
  input wire logic [N_BIDIR-1:0] bd_core_oe_i,
  input wire logic [N_BIDIR-1:0] bd_pad_oe_o
);
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (sys_rst_i);

  tdo_on_fall_a:
    assert property ($changed(tdo_o) |-> !$past(tck_i) && !$past(tck_i, 2))
    else $error("tdo_o moved outside a test clock low phase");
  oe_on_fall_a:
    assert property ($changed(tdo_oe_o) |-> !$past(tck_i) && !$past(tck_i, 2))
    else $error("tdo_oe_o moved outside a test clock low phase");
  oe_min_width_a:
    assert property ($rose(tdo_oe_o) |-> tdo_oe_o [*6])
    else $error("tdo_oe_o pulse shorter than a shift cycle");
  highz_all_a:
    assert property (out_pad_oe_o != '1 && !$past(sys_rst_i, 3)
      |-> out_pad_oe_o == '0)
    else $error("output enables split between on and off");
  highz_bd_a:
    assert property (out_pad_oe_o == '0 && !$past(sys_rst_i, 3)
      |-> bd_pad_oe_o == '0)
    else $error("two-way enable on while outputs are off");
  instr_on_fall_a:
    assert property ($changed(out_pad_oe_o) && trst_n_i && $past(trst_n_i, 4)
      && !$past(sys_rst_i, 3) |-> !$past(tck_i) && !$past(tck_i, 2))
    else $error("instruction took effect away from a fall");
  bd_oe_on_fall_a:
    assert property ($changed(bd_pad_oe_o) && $stable(bd_core_oe_i)
      && $past(bd_core_oe_i) == $past(bd_core_oe_i, 2) && trst_n_i
      && $past(trst_n_i, 4) && !$past(sys_rst_i, 3)
      |-> !$past(tck_i) && !$past(tck_i, 2))
    else $error("two-way enable changed away from a fall");
  trst_idcode_a:
    assert property (!trst_n_i [*5] |=> out_pad_oe_o == '1)
    else $error("test reset left pins under test control");

  cover property ($rose(tdo_oe_o));
  cover property (out_pad_oe_o == '0);
  cover property (bd_pad_oe_o != bd_core_oe_i);
endmodule

bind bsil_top bsil_checker #(.N_OUT(N_OUT), .N_BIDIR(N_BIDIR)) u_checker (
  .clock_i(clock_i), .sys_rst_i(sys_rst_i), .tck_i(tck_i),
  .trst_n_i(trst_n_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
  .out_pad_oe_o(out_pad_oe_o), .bd_core_oe_i(bd_core_oe_i),
  .bd_pad_oe_o(bd_pad_oe_o));

`default_nettype wire

// *** verification/bsil_tester.sv ***
/*
  Board tester model: runs one frame of test clocks on request.
  Assumes requests come by go_i at clock_i; tck stands low between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module bsil_tester (
  // Clock and request
  input wire logic clock_i,
  input wire logic go_i,
  input wire logic [6:0] len_i,
  input wire logic [63:0] tms_v_i,
  input wire logic [63:0] tdi_v_i,
  // Test port
  input wire logic tdo_i,
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  // Result
  output logic [63:0] tdo_v_o,
  output logic busy_o
);
  initial
  begin
    tck_o = 1'h0;
    tms_o = 1'h1;
    tdi_o = 1'h1;
    tdo_v_o = '0;
    busy_o = 1'h0;
  end

  // Four cycles low, four high; tms and tdi move at each fall
  always @(posedge clock_i)
  begin
    if (go_i && !busy_o)
    begin
      busy_o <= 1'h1;
      for (int k = 0; k < int'(len_i); k++)
      begin
        tck_o <= 1'h0;
        tms_o <= tms_v_i[k];
        tdi_o <= tdi_v_i[k];
        repeat (3) @(posedge clock_i);
        @(negedge clock_i);
        tdo_v_o[k] <= tdo_i;
        @(posedge clock_i);
        tck_o <= 1'h1;
        repeat (4) @(posedge clock_i);
      end
      // Released tms and tdi fall back to their pull-ups; tck rests low
      tck_o <= 1'h0;
      tms_o <= 1'h1;
      tdi_o <= 1'h1;
      busy_o <= 1'h0;
    end
  end
endmodule

`default_nettype wire

// *** verification/bsil_top_test.sv ***
/*
  Self-checking bench for bsil_top, one task per scenario.
  Assumes bsil_tester as the far side and the bound port checker.
*/
`timescale 1ns/1ps
`default_nettype none

module bsil_top_test;
  // Identification values are arbitrary
  localparam logic [3:0] VER = 4'h6;
  localparam logic [15:0] PART = 16'h1357;
  localparam logic [10:0] MANUF = 11'h4C2;
  localparam logic [63:0] ID = {32'h0, VER, PART, MANUF, 1'h1};
  logic clock_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic trst_n_i = 1'h1;
  logic go = 1'h0;
  logic [6:0] len = 7'h0;
  logic [63:0] tms_v = '0;
  logic [63:0] tdi_v = '0;
  logic [63:0] tdo_v;
  logic [63:0] d;
  logic busy, tck, tms, tdi, tdo, tdo_oe, tdo_line;
  logic [3:0] in_pad = 4'hA;
  logic [3:0] core_out = 4'h5;
  logic [3:0] bd_out = 4'h6;
  logic [3:0] bd_oe = 4'h3;
  logic [3:0] bd_ext = 4'h9;
  logic [3:0] bd_pad, pin_out, pin_oe, bd_drv, bd_drv_oe;
  logic [15:0] pins;
  int fails = 0;
  int total_checks = 0;

  always #25 clock_i = ~clock_i;
  // Two-way wire level from both drivers
  assign bd_pad = (bd_drv_oe & bd_drv) | (~bd_drv_oe & bd_ext);
  assign pins = {bd_drv, bd_drv_oe, pin_out, pin_oe};
  // Released serial out has no pull; the line shows the inverse
  assign tdo_line = tdo_oe ? tdo : ~tdo;

  bsil_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MANUF(MANUF)) i_dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(trst_n_i), .tdo_o(tdo), .tdo_oe_o(tdo_oe),
    .in_pad_i(in_pad), .core_out_i(core_out), .out_pad_o(pin_out),
    .out_pad_oe_o(pin_oe), .bd_core_out_i(bd_out), .bd_core_oe_i(bd_oe),
    .bd_pad_i(bd_pad), .bd_pad_o(bd_drv), .bd_pad_oe_o(bd_drv_oe));
  bsil_tester i_tester (.clock_i(clock_i), .go_i(go), .len_i(len),
    .tms_v_i(tms_v), .tdi_v_i(tdi_v), .tdo_i(tdo_line), .tck_o(tck),
    .tms_o(tms), .tdi_o(tdi), .tdo_v_o(tdo_v), .busy_o(busy));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One frame of n test clocks, waited for under a bound
  task automatic run(input int n, input logic [63:0] tm,
                     input logic [63:0] ti);
    int w;
    logic seen;
    w = 0;
    seen = 1'h0;
    @(posedge clock_i);
    len <= 7'(n);
    tms_v <= tm;
    tdi_v <= ti;
    go <= 1'h1;
    while (!(seen && busy === 1'h0) && w < 900)
    begin
      @(posedge clock_i);
      if (busy === 1'h1)
      begin
        go <= 1'h0;
        seen = 1'h1;
      end
      w++;
    end
    if (w >= 900)
    begin
      fails++;
      $display("ERROR tester frame expected done seen hang");
      give_verdict();
    end
    @(negedge clock_i);
  endtask

  // From idle: scan n bits into IR or DR, back to idle
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    int p;
    p = ir ? 4 : 3;
    run(p + n + 2, (ir ? 64'h3 : 64'h1) | (64'h3 << (p + n - 1)), din << p);
    dout = (tdo_v >> p) & ((64'h1 << n) - 64'h1);
  endtask

  task automatic t_idcode;
    run(1, 64'h0, 64'h0);
    scan(0, 32, 64'h0, d);
    check("idcode", ID, d);
    $display("test idcode done");
  endtask

  task automatic t_bypass;
    scan(1, 6, 64'(bsil_pkg::OP_BYPASS), d);
    check("ir capture", 64'(bsil_pkg::CAPTURE_IR_PATTERN_INSTR), d);
    scan(0, 8, 64'hB4, d);
    check("bypass", 64'h68, d);
    check("tdo idle", 64'h0, 64'(tdo_oe));
    $display("test bypass done");
  endtask

  task automatic t_highz;
    scan(1, 6, 64'(bsil_pkg::OP_HIGHZ), d);
    check("highz enables", 64'h0, 64'({bd_drv_oe, pin_oe}));
    scan(0, 4, 64'hB, d);
    check("highz path", 64'h6, d);
    $display("test highz done");
  endtask

  task automatic t_reserved;
    logic [5:0] ops [6] = '{6'h04, 6'h2C, 6'h2D, 6'h2E, 6'h3C, 6'h3D};
    foreach (ops[i])
    begin
      scan(1, 6, 64'(ops[i]), d);
      check("reserved pins", 64'({bd_out, bd_oe, core_out, 4'hF}),
            64'(pins));
      scan(0, 2, 64'h3, d);
      check("reserved path", 64'h2, d);
    end
    $display("test reserved done");
  endtask

  task automatic t_sample;
    scan(1, 6, 64'(bsil_pkg::OP_SAMPLE), d);
    scan(0, 16, 64'h6C93, d);
    check("sample capture", 64'hA35A, d);
    check("sample pins", 64'h635F, 64'(pins));
    $display("test sample done");
  endtask

  task automatic t_extest;
    scan(1, 6, 64'(bsil_pkg::OP_EXTEST), d);
    check("extest preload", 64'h6C9F, 64'(pins));
    scan(0, 16, 64'h3A50, d);
    check("extest capture", 64'h535A, d);
    check("extest update", 64'h3A5F, 64'(pins));
    $display("test extest done");
  endtask

  task automatic t_clamp;
    scan(1, 6, 64'(bsil_pkg::OP_CLAMP), d);
    check("clamp hold", 64'h3A5F, 64'(pins));
    scan(0, 4, 64'h9, d);
    check("clamp path", 64'h2, d);
    $display("test clamp done");
  endtask

  task automatic t_trst;
    scan(1, 6, 64'(bsil_pkg::OP_BYPASS), d);
    run(6, 64'h1F, 64'h0);
    scan(0, 32, 64'h0, d);
    check("tms reset idcode", ID, d);
    scan(1, 6, 64'(bsil_pkg::OP_HIGHZ), d);
    @(posedge clock_i);
    trst_n_i <= 1'h0;
    core_out <= 4'hC;
    repeat (6) @(posedge clock_i);
    trst_n_i <= 1'h1;
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    check("trst pins", 64'h63CF, 64'(pins));
    run(1, 64'h0, 64'h0);
    scan(0, 32, 64'h0, d);
    check("trst idcode", ID, d);
    $display("test trst done");
  endtask

  initial
  begin
    repeat (3) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    repeat (6) @(posedge clock_i);
    t_idcode();
    t_bypass();
    t_highz();
    t_reserved();
    t_sample();
    t_extest();
    t_clamp();
    t_trst();
    give_verdict();
  end
endmodule

`default_nettype wire
